// *** core/tmr_pkg.sv ***
// Purpose: Shared constants and types for the 16-bit timer byte-access core
// Assumes: 8-bit CPU data path, one clock domain
// Notes: Field positions follow the control and flag register layouts
package tmr_pkg;

  // Data widths
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;

  // Counter landmarks and fixed TOP values
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] WORD_ONE = 16'h0001;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Control register A fields
  localparam int CA_WAVE0 = 0;
  localparam int CA_WAVE1 = 1;
  // Control register B fields
  localparam int CB_CLKSEL_LSB = 0;
  localparam int CB_CLKSEL_MSB = 2;
  localparam int CB_WAVE2 = 3;
  localparam int CB_WAVE3 = 4;
  localparam int CB_EDGE = 6;
  localparam int CB_FILT = 7;
  // Control register C fields
  localparam int CC_FORCE_B = 6;
  localparam int CC_FORCE_A = 7;
  // Flag and mask register fields
  localparam int FL_OVF = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  localparam int FL_CAPT = 5;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Noise filter sample count
  localparam int FILT_DEPTH = 4;

  // Byte locations the CPU can reach
  typedef enum logic [3:0] {
    SEL_COUNT_LO, SEL_COUNT_HI, SEL_CMPA_LO, SEL_CMPA_HI, SEL_CMPB_LO, SEL_CMPB_HI,
    SEL_CAPT_LO, SEL_CAPT_HI, SEL_CTRL_A, SEL_CTRL_B, SEL_CTRL_C, SEL_FLAGS, SEL_MASK
  } tmr_sel_t;

  // One CPU byte access
  typedef struct packed {
    logic rd;
    logic wr;
    tmr_sel_t sel;
    logic [7:0] wdata;
  } tmr_cpu_req_t;

endpackage : tmr_pkg

// *** core/tmr_pin_sync.sv ***
// Purpose: Three-stage synchroniser for an asynchronous pin
// Assumes: Pin is unrelated to clk
// Notes: Output level moves only when stages two and three agree
`timescale 1ns/100ps
module tmr_pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level
);
  import tmr_pkg::*;

  logic s1_ff; // Metastability catcher, read only by s2_ff
  logic s2_ff; // Second stage
  logic s3_ff; // Third stage
  logic level_ff; // Accepted level

  // Shift chain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a change only once two settled stages agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign level = level_ff;

  a_sync_agree: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(level_ff) |-> $past(s2_ff == s3_ff)) else $error("sync level moved without agreement");

endmodule : tmr_pin_sync

// *** core/tmr_noise_filt.sv ***
// Purpose: Optional four-sample filter in front of the capture edge detector
// Assumes: Input already synchronised to clk
// Notes: Adds latency when enabled; bypass follows input one cycle later
`timescale 1ns/100ps
module tmr_noise_filt (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  import tmr_pkg::*;

  logic [FILT_DEPTH-1:0] hist_ff; // Last samples, newest in bit 0
  logic dout_ff; // Filtered level

  // Sample history
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hist_ff <= '0;
    end else begin
      hist_ff <= {hist_ff[FILT_DEPTH-2:0], din};
    end
  end

  // When enabled, output changes only when every sample agrees
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dout_ff <= 1'b0;
    end else if (!enable) begin
      dout_ff <= din; // Bypass
    end else if (&hist_ff) begin
      dout_ff <= 1'b1;
    end else if (~|hist_ff) begin
      dout_ff <= 1'b0;
    end
  end

  assign dout = dout_ff;

  a_filt_unanimous: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(enable) && $changed(dout_ff)) |-> ($past(&hist_ff) || $past(~|hist_ff)))
    else $error("filter output moved on mixed samples");

endmodule : tmr_noise_filt

// *** core/tmr_core.sv ***
// Purpose: CPU-facing core of a 16-bit timer with shared high-byte holding register
// Assumes: CPU byte accesses arrive as one-cycle strobes on clk; prescaler tick comes from same clock
// Notes: Waveform pins and prescaler taps live in neighbouring blocks
`timescale 1ns/100ps
module tmr_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire tmr_pkg::tmr_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  input wire logic presc_tick,
  input wire logic ext_count_pin,
  input wire logic capture_in_pin,
  input wire logic acomp_out,
  input wire logic acomp_capture_sel,
  output logic [7:0] timer_irq_req,
  output logic compare_match_a,
  output logic compare_match_b,
  output logic pwm_a_allowed,
  output logic timer_tick,
  output logic at_bottom,
  output logic at_max,
  output logic at_top
);
  import tmr_pkg::*;
  // Mode decoding helpers
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
  endfunction : is_pwm
  function automatic logic top_is_cmpa(input logic [3:0] m);
    top_is_cmpa = (m == 4'h4 || m == 4'h9 || m == 4'hB || m == 4'hF);
  endfunction : top_is_cmpa
  function automatic logic top_is_capt(input logic [3:0] m);
    top_is_capt = (m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE);
  endfunction : top_is_capt
  function automatic logic [15:0] top_value(input logic [3:0] m, input logic [15:0] a, input logic [15:0] c);
    if (top_is_cmpa(m)) begin
      top_value = a;
    end else if (top_is_capt(m)) begin
      top_value = c;
    end else if (m[1:0] == 2'h1) begin
      top_value = TOP_8BIT;
    end else if (m[1:0] == 2'h2) begin
      top_value = TOP_9BIT;
    end else if (m[1:0] == 2'h3) begin
      top_value = TOP_10BIT;
    end else begin
      top_value = MAX_VAL;
    end
  endfunction : top_value
  // State
  logic [15:0] count_ff; // Counter value
  logic [15:0] nxt_count;
  logic [15:0] cmpa_buf_ff; // Compare A as written by the CPU
  logic [15:0] cmpb_buf_ff; // Compare B as written by the CPU
  logic [15:0] cmpa_act_ff; // Compare A as used by the comparator
  logic [15:0] cmpb_act_ff; // Compare B as used by the comparator
  logic [15:0] capt_ff; // Captured value or TOP
  logic [7:0] hold_ff; // Shared high-byte holding register
  logic [7:0] ctrl_a_ff; // Control register A
  logic [7:0] ctrl_b_ff; // Control register B
  logic [7:0] flags_ff; // Request flags
  logic [7:0] nxt_flags;
  logic [7:0] mask_ff; // Request mask
  logic [7:0] rdata_ff; // Read answer
  logic [7:0] irq_ff; // Masked requests
  logic match_a_ff, match_b_ff, pwm_a_ok_ff, tick_ff, bottom_ff, max_ff, top_ff;
  logic ext_prev_ff; // Previous external pin level
  logic capt_prev_ff; // Previous filtered capture level
  // Decoded controls
  logic [3:0] mode;
  logic [2:0] clk_sel;
  logic [15:0] top;
  logic tick, at_wrap, ext_lvl, icp_lvl, acmp_lvl, capt_lvl, capt_evt;
  logic wr_count, wr_capt, force_a, force_b, hit_a, hit_b;
  logic [7:0] flag_clr, flag_set;
  assign mode = {ctrl_b_ff[CB_WAVE3], ctrl_b_ff[CB_WAVE2], ctrl_a_ff[CA_WAVE1], ctrl_a_ff[CA_WAVE0]};
  assign clk_sel = ctrl_b_ff[CB_CLKSEL_MSB:CB_CLKSEL_LSB];
  assign top = top_value(mode, cmpa_act_ff, capt_ff);
  assign at_wrap = tick && (count_ff == top);
  // Pin synchronisers
  tmr_pin_sync u_ext_sync (.clk(clk), .rst_b(rst_b), .pin(ext_count_pin), .level(ext_lvl));
  tmr_pin_sync u_icp_sync (.clk(clk), .rst_b(rst_b), .pin(capture_in_pin), .level(icp_lvl));
  tmr_pin_sync u_acmp_sync (.clk(clk), .rst_b(rst_b), .pin(acomp_out), .level(acmp_lvl));
  // Capture source choice then optional filter
  tmr_noise_filt u_filt (
    .clk(clk),
    .rst_b(rst_b),
    .enable(ctrl_b_ff[CB_FILT]),
    .din(acomp_capture_sel ? acmp_lvl : icp_lvl),
    .dout(capt_lvl)
  );
  // Edge history for external clock and capture
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_prev_ff <= 1'b0;
      capt_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_lvl;
      capt_prev_ff <= capt_lvl;
    end
  end

  // Timer tick source; code zero leaves the counter idle
  always_comb begin
    if (clk_sel == CS_STOP) begin
      tick = 1'b0;
    end else if (clk_sel == CS_DIRECT) begin
      tick = 1'b1;
    end else if (clk_sel == CS_EXT_FALL) begin
      tick = ext_prev_ff && !ext_lvl;
    end else if (clk_sel == CS_EXT_RISE) begin
      tick = !ext_prev_ff && ext_lvl;
    end else begin
      tick = presc_tick; // Tap chosen by the prescaler block
    end
  end
  // Capture is silent while the capture register serves as TOP
  assign capt_evt = !top_is_capt(mode) &&
                    (ctrl_b_ff[CB_EDGE] ? (!capt_prev_ff && capt_lvl) : (capt_prev_ff && !capt_lvl));

  // Access strobes
  assign wr_count = cpu_req.wr && cpu_req.sel == SEL_COUNT_LO;
  assign wr_capt = cpu_req.wr && cpu_req.sel == SEL_CAPT_LO && top_is_capt(mode);
  assign force_a = cpu_req.wr && cpu_req.sel == SEL_CTRL_C && cpu_req.wdata[CC_FORCE_A] && !is_pwm(mode);
  assign force_b = cpu_req.wr && cpu_req.sel == SEL_CTRL_C && cpu_req.wdata[CC_FORCE_B] && !is_pwm(mode);
  assign hit_a = tick && (count_ff == cmpa_act_ff);
  assign hit_b = tick && (count_ff == cmpb_act_ff);
  // Counter: CPU write wins over counting and wrap
  always_comb begin
    nxt_count = count_ff;
    if (wr_count) begin
      nxt_count = {hold_ff, cpu_req.wdata};
    end else if (at_wrap) begin
      nxt_count = BOTTOM_VAL;
    end else if (tick) begin
      nxt_count = count_ff + WORD_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_ff <= WORD_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Holding register: high-byte writes fill it, low-byte reads of counter and capture load it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_ff <= BYTE_RST;
    end else if (cpu_req.wr && (cpu_req.sel == SEL_COUNT_HI || cpu_req.sel == SEL_CMPA_HI ||
                                cpu_req.sel == SEL_CMPB_HI || cpu_req.sel == SEL_CAPT_HI)) begin
      hold_ff <= cpu_req.wdata;
    end else if (cpu_req.rd && cpu_req.sel == SEL_COUNT_LO) begin
      hold_ff <= count_ff[15:8];
    end else if (cpu_req.rd && cpu_req.sel == SEL_CAPT_LO) begin
      hold_ff <= capt_ff[15:8];
    end
  end
  // Compare buffers; in PWM modes the active copy loads only at TOP, so a running TOP can change safely
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmpa_buf_ff <= WORD_RST;
      cmpb_buf_ff <= WORD_RST;
      cmpa_act_ff <= WORD_RST;
      cmpb_act_ff <= WORD_RST;
    end else begin
      if (cpu_req.wr && cpu_req.sel == SEL_CMPA_LO) begin
        cmpa_buf_ff <= {hold_ff, cpu_req.wdata};
      end
      if (cpu_req.wr && cpu_req.sel == SEL_CMPB_LO) begin
        cmpb_buf_ff <= {hold_ff, cpu_req.wdata};
      end
      if (!is_pwm(mode) || at_wrap) begin
        cmpa_act_ff <= cmpa_buf_ff;
        cmpb_act_ff <= cmpb_buf_ff;
      end
    end
  end
  // Capture register: hardware capture takes precedence over a CPU write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      capt_ff <= WORD_RST;
    end else if (capt_evt) begin
      capt_ff <= count_ff;
    end else if (wr_capt) begin
      capt_ff <= {hold_ff, cpu_req.wdata};
    end
  end
  // Plain byte control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_a_ff <= BYTE_RST;
      ctrl_b_ff <= BYTE_RST;
      mask_ff <= BYTE_RST;
    end else if (cpu_req.wr) begin
      if (cpu_req.sel == SEL_CTRL_A) begin
        ctrl_a_ff <= cpu_req.wdata;
      end else if (cpu_req.sel == SEL_CTRL_B) begin
        ctrl_b_ff <= cpu_req.wdata;
      end else if (cpu_req.sel == SEL_MASK) begin
        mask_ff <= cpu_req.wdata;
      end
    end
  end
  // Flags: writing one clears, but a same-cycle event wins
  assign flag_clr = (cpu_req.wr && cpu_req.sel == SEL_FLAGS) ? cpu_req.wdata : BYTE_RST;
  always_comb begin
    flag_set = BYTE_RST;
    flag_set[FL_OVF] = at_wrap;
    flag_set[FL_CMPA] = hit_a;
    flag_set[FL_CMPB] = hit_b;
    flag_set[FL_CAPT] = capt_evt;
    nxt_flags = (flags_ff & ~flag_clr) | flag_set;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_ff <= BYTE_RST;
      irq_ff <= BYTE_RST;
    end else begin
      flags_ff <= nxt_flags;
      irq_ff <= nxt_flags & ((cpu_req.wr && cpu_req.sel == SEL_MASK) ? cpu_req.wdata : mask_ff);
    end
  end
  // Read answer, one cycle after the strobe; compare bytes come straight from the buffers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_ff <= BYTE_RST;
    end else if (cpu_req.rd) begin
      if (cpu_req.sel == SEL_COUNT_LO) begin
        rdata_ff <= count_ff[7:0];
      end else if (cpu_req.sel == SEL_COUNT_HI || cpu_req.sel == SEL_CAPT_HI) begin
        rdata_ff <= hold_ff;
      end else if (cpu_req.sel == SEL_CMPA_LO) begin
        rdata_ff <= cmpa_buf_ff[7:0];
      end else if (cpu_req.sel == SEL_CMPA_HI) begin
        rdata_ff <= cmpa_buf_ff[15:8];
      end else if (cpu_req.sel == SEL_CMPB_LO) begin
        rdata_ff <= cmpb_buf_ff[7:0];
      end else if (cpu_req.sel == SEL_CMPB_HI) begin
        rdata_ff <= cmpb_buf_ff[15:8];
      end else if (cpu_req.sel == SEL_CAPT_LO) begin
        rdata_ff <= capt_ff[7:0];
      end else if (cpu_req.sel == SEL_CTRL_A) begin
        rdata_ff <= ctrl_a_ff;
      end else if (cpu_req.sel == SEL_CTRL_B) begin
        rdata_ff <= ctrl_b_ff;
      end else if (cpu_req.sel == SEL_FLAGS) begin
        rdata_ff <= flags_ff;
      end else if (cpu_req.sel == SEL_MASK) begin
        rdata_ff <= mask_ff;
      end else begin
        rdata_ff <= BYTE_RST; // Force bits are strobes and read as zero
      end
    end
  end
  // Status outputs; bottom, max and top registered from next-state values so they line up with the counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      match_a_ff <= 1'b0;
      match_b_ff <= 1'b0;
      pwm_a_ok_ff <= 1'b1;
      tick_ff <= 1'b0;
      bottom_ff <= 1'b1;
      max_ff <= 1'b0;
      top_ff <= 1'b0;
    end else begin
      match_a_ff <= hit_a || force_a;
      match_b_ff <= hit_b || force_b;
      pwm_a_ok_ff <= !(is_pwm(mode) && top_is_cmpa(mode));
      tick_ff <= tick;
      bottom_ff <= (nxt_count == BOTTOM_VAL);
      max_ff <= (nxt_count == MAX_VAL);
      top_ff <= (nxt_count == top);
    end
  end
  assign cpu_rdata = rdata_ff;
  assign timer_irq_req = irq_ff;
  assign compare_match_a = match_a_ff;
  assign compare_match_b = match_b_ff;
  assign pwm_a_allowed = pwm_a_ok_ff;
  assign timer_tick = tick_ff;
  assign at_bottom = bottom_ff;
  assign at_max = max_ff;
  assign at_top = top_ff;
  // Checks; the two-byte write allows one idle cycle, which must not touch the holding byte
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_hi_then_lo;
    (cpu_req.wr && cpu_req.sel == SEL_COUNT_HI) ##1 (!cpu_req.wr && !cpu_req.rd) ##1
    (cpu_req.wr && cpu_req.sel == SEL_COUNT_LO);
  endsequence
  a_word_write: assert property (s_hi_then_lo |=> count_ff == {$past(cpu_req.wdata, 3), $past(cpu_req.wdata)})
    else $error("two-byte counter write did not land");
  a_write_priority: assert property (wr_count |=> count_ff == {$past(hold_ff), $past(cpu_req.wdata)})
    else $error("counter write lost to counting");
  a_lo_read_hold: assert property ((cpu_req.rd && cpu_req.sel == SEL_COUNT_LO && !cpu_req.wr) |=>
    hold_ff == $past(count_ff[15:8])) else $error("holding register not loaded on low read");
  a_cmp_bypass: assert property ((cpu_req.rd && !cpu_req.wr && cpu_req.sel == SEL_CMPA_HI) |=>
    $stable(hold_ff) && rdata_ff == $past(cmpa_buf_ff[15:8])) else $error("compare read touched holding");
  a_ctrl_direct: assert property ((cpu_req.wr && cpu_req.sel == SEL_CTRL_B) |=> ctrl_b_ff == $past(cpu_req.wdata))
    else $error("control byte not taken directly");
  a_irq_masked: assert property (irq_ff == (flags_ff & mask_ff)) else $error("request not gated by mask");
  a_stop_idle: assert property ((clk_sel == CS_STOP && !wr_count) |=> $stable(count_ff))
    else $error("counter moved with no clock source");
  a_cmp_flag: assert property (hit_a |=> flags_ff[FL_CMPA] && match_a_ff) else $error("compare A match missed");
  a_capt_copy: assert property (capt_evt |=> capt_ff == $past(count_ff) && flags_ff[FL_CAPT])
    else $error("capture did not copy counter");
  a_pwm_a_off: assert property ((is_pwm(mode) && top_is_cmpa(mode)) |=> !pwm_a_ok_ff)
    else $error("channel A output allowed while it is TOP");
  a_bottom_max: assert property (bottom_ff == (count_ff == BOTTOM_VAL) && max_ff == (count_ff == MAX_VAL))
    else $error("bottom or max indication wrong");
  a_capt_gate: assert property ((cpu_req.wr && cpu_req.sel == SEL_CAPT_LO && !top_is_capt(mode) && !capt_evt) |=>
    $stable(capt_ff)) else $error("capture written while not TOP");
endmodule : tmr_core

// *** verif/tmr_cpu_model.sv ***
// Purpose: CPU-side model issuing byte accesses to the timer core
// Assumes: Strobes change at the falling edge; the answer is registered one cycle later
// Notes: A two-byte access is never split, so nothing else can disturb the shared high byte
`timescale 1ns/100ps
module tmr_cpu_model (
  input wire logic clk,
  input wire logic [7:0] cpu_rdata,
  output tmr_pkg::tmr_cpu_req_t cpu_req
);
  import tmr_pkg::*;

  // Bus idle from time zero
  initial begin
    cpu_req = '0;
  end

  // One strobe cycle, then idle; the answer has settled by the next falling edge
  task automatic access(input logic rd_en, input logic wr_en, input tmr_sel_t sel, input logic [7:0] wd,
      output logic [7:0] val);
    @(negedge clk);
    cpu_req <= tmr_cpu_req_t'{rd_en, wr_en, sel, wd};
    @(negedge clk);
    cpu_req <= '0;
    val = cpu_rdata;
  endtask : access

  // Single byte write
  task automatic wr8(input tmr_sel_t sel, input logic [7:0] wd);
    logic [7:0] unused;
    access(1'b0, 1'b1, sel, wd, unused);
  endtask : wr8

  // Single byte read
  task automatic rd8(input tmr_sel_t sel, output logic [7:0] val);
    access(1'b1, 1'b0, sel, 8'h00, val);
  endtask : rd8

  // High byte first, so the low write lands the whole word; no interleaving allowed
  task automatic wr16(input tmr_sel_t lo, input logic [15:0] val);
    wr8(tmr_sel_t'(lo + 4'h1), val[15:8]);
    wr8(lo, val[7:0]);
  endtask : wr16

  // Low byte first; for counter and capture it latches the high byte for the second read
  task automatic rd16(input tmr_sel_t lo, output logic [15:0] val);
    rd8(lo, val[7:0]);
    rd8(tmr_sel_t'(lo + 4'h1), val[15:8]);
  endtask : rd16
endmodule : tmr_cpu_model

// *** verif/tb_timer16_byte_access_core.sv ***
// Purpose: Self-checking bench for the timer byte-access core
// Assumes: Inputs change at the falling edge; counter stopped unless a case runs it
// Notes: Table rows cover mode landmarks; hand-written cases cover holding byte and events
`timescale 1ns/100ps
module tb_timer16_byte_access_core;
  import tmr_pkg::*;

  // Row: mode, counter value, expected {bottom, max, top}
  typedef struct {logic [3:0] mode; logic [15:0] cnt; logic [2:0] lm;} tmr_row_t;
  tmr_row_t rows [8] = '{'{4'h0, 16'h0000, 3'h4}, '{4'h0, 16'hFFFF, 3'h3}, '{4'h1, 16'h00FF, 3'h1},
    '{4'h2, 16'h01FF, 3'h1}, '{4'h3, 16'h03FF, 3'h1}, '{4'h3, 16'h01FF, 3'h0}, '{4'h4, 16'h0000, 3'h5},
    '{4'hC, 16'h1234, 3'h0}};
  logic clk = 1'b0;
  logic rst_b, ext_pin, cap_pin, acomp, acomp_sel, presc;
  logic [7:0] cpu_rdata, irq, b8;
  logic [15:0] w16, w2;
  logic m_a, m_b, pwm_ok, tick, at_bot, at_max, at_top;
  tmr_cpu_req_t cpu_req;
  int err_count = 0;
  int checks_done = 0;
  int n_a = 0;
  int n_b = 0;
  int n_t = 0;
  int mark_a, mark_b, mark_t;

  tmr_cpu_model i_cpu (.clk(clk), .cpu_rdata(cpu_rdata), .cpu_req(cpu_req));
  tmr_core i_dut (.clk(clk), .rst_b(rst_b), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .presc_tick(presc),
    .ext_count_pin(ext_pin), .capture_in_pin(cap_pin), .acomp_out(acomp), .acomp_capture_sel(acomp_sel),
    .timer_irq_req(irq), .compare_match_a(m_a), .compare_match_b(m_b), .pwm_a_allowed(pwm_ok),
    .timer_tick(tick), .at_bottom(at_bot), .at_max(at_max), .at_top(at_top));

  // Free-running clock, 8 ns period
  always #4 clk = ~clk;

  // Count match pulses; one-cycle strobes are easy to miss by polling
  always @(posedge clk) begin
    if (m_a === 1'b1) n_a <= n_a + 1;
    if (m_b === 1'b1) n_b <= n_b + 1;
    if (tick === 1'b1) n_t <= n_t + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Mode, clock select and {filter, edge}; both controls read back as written
  task automatic set_mode(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] hi);
    logic [7:0] va;
    logic [7:0] vb;
    va = {6'h00, m[1:0]};
    vb = {hi, 1'b0, m[3:2], cs};
    i_cpu.wr8(SEL_CTRL_A, va);
    i_cpu.wr8(SEL_CTRL_B, vb);
    i_cpu.rd8(SEL_CTRL_A, b8);
    check(16'(b8), 16'(va), "ctrl a");
    i_cpu.rd8(SEL_CTRL_B, b8);
    check(16'(b8), 16'(vb), "ctrl b");
  endtask : set_mode

  // Whole run is well under 2000 cycles; this bound only catches a hang
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    presc = 1'b0;
    rst_b = 1'b0;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    acomp = 1'b0;
    acomp_sel = 1'b0;
    idle(20);
    check({irq, cpu_rdata}, 16'h0000, "rst outs");
    check(16'({at_bot, at_max, pwm_ok, m_a, m_b}), 16'h0014, "rst marks");
    rst_b = 1'b1;
    foreach (rows[i]) begin
      set_mode(rows[i].mode, CS_STOP, 2'h0);
      i_cpu.wr16(SEL_COUNT_LO, rows[i].cnt);
      i_cpu.rd16(SEL_COUNT_LO, w16);
      check(w16, rows[i].cnt, "count rb");
      check(16'({at_bot, at_max, at_top}), 16'(rows[i].lm), "marks");
    end
    // Compare reads must leave the latched counter high byte alone
    set_mode(4'h0, CS_STOP, 2'h0);
    i_cpu.wr16(SEL_CMPA_LO, 16'h3456);
    i_cpu.wr16(SEL_COUNT_LO, 16'hAB12);
    i_cpu.rd8(SEL_COUNT_LO, b8);
    i_cpu.rd16(SEL_CMPA_LO, w16);
    check(w16, 16'h3456, "cmp direct");
    i_cpu.rd8(SEL_COUNT_HI, b8);
    check(16'(b8), 16'h00AB, "hold kept");
    // One high byte serves two registers
    i_cpu.wr8(SEL_COUNT_HI, 8'h77);
    i_cpu.wr8(SEL_COUNT_LO, 8'h01);
    i_cpu.wr8(SEL_CMPB_LO, 8'h02);
    i_cpu.rd16(SEL_CMPB_LO, w16);
    check(w16, 16'h7702, "shared hold");
    // Write while counting, then stop
    set_mode(4'h0, CS_DIRECT, 2'h0);
    i_cpu.wr16(SEL_COUNT_LO, 16'h1000);
    i_cpu.wr8(SEL_CTRL_B, 8'h00);
    i_cpu.rd16(SEL_COUNT_LO, w16);
    check(w16, 16'h1002, "write wins");
    i_cpu.rd16(SEL_COUNT_LO, w2);
    check(w2, w16, "stopped");
    // External pin, rising then falling edge: three pulses give three counts
    for (int k = 0; k < 2; k++) begin
      i_cpu.wr16(SEL_COUNT_LO, 16'h0000);
      set_mode(4'h0, (k == 0) ? CS_EXT_RISE : CS_EXT_FALL, 2'h0);
      repeat (3) begin
        ext_pin = 1'b1;
        idle(8);
        ext_pin = 1'b0;
        idle(8);
      end
      i_cpu.wr8(SEL_CTRL_B, 8'h00);
      i_cpu.rd16(SEL_COUNT_LO, w16);
      check(w16, 16'h0003, "ext count");
    end
    // Compare B hit while running, flag masked then unmasked then cleared
    i_cpu.wr16(SEL_CMPB_LO, 16'h0010);
    i_cpu.wr16(SEL_COUNT_LO, 16'h0000);
    i_cpu.wr8(SEL_FLAGS, 8'hFF);
    mark_b = n_b;
    set_mode(4'h0, CS_DIRECT, 2'h0);
    idle(30);
    i_cpu.wr8(SEL_CTRL_B, 8'h00);
    check(16'(n_b - mark_b), 16'h0001, "match b");
    i_cpu.rd8(SEL_FLAGS, b8);
    check(16'(b8 & 8'h27), 16'h0004, "flag b");
    check(16'(irq), 16'h0000, "masked");
    i_cpu.wr8(SEL_MASK, 8'h04);
    idle(1);
    check(16'(irq), 16'h0004, "unmasked");
    i_cpu.wr8(SEL_FLAGS, 8'h04);
    idle(1);
    check(16'(irq), 16'h0000, "cleared");
    // Capture is writable only when it defines TOP
    i_cpu.wr16(SEL_CAPT_LO, 16'h5555);
    i_cpu.rd16(SEL_CAPT_LO, w16);
    check(w16, 16'h0000, "capt locked");
    set_mode(4'hE, CS_STOP, 2'h0);
    i_cpu.wr16(SEL_CAPT_LO, 16'h5555);
    i_cpu.rd16(SEL_CAPT_LO, w16);
    check(w16, 16'h5555, "capt top");
    check(16'(pwm_ok), 16'h0001, "pwm a free");
    set_mode(4'hF, CS_STOP, 2'h0);
    idle(1);
    check(16'(pwm_ok), 16'h0000, "pwm a top");
    // Force strobe pulses the match but reads back zero
    set_mode(4'h0, CS_STOP, 2'h0);
    mark_a = n_a;
    i_cpu.wr8(SEL_CTRL_C, 8'h80);
    i_cpu.rd8(SEL_CTRL_C, b8);
    check(16'(b8), 16'h0000, "force rd");
    check(16'(n_a - mark_a), 16'h0001, "force a");
    // Capture from the pin, then from the comparator through the filter
    i_cpu.wr16(SEL_COUNT_LO, 16'h0200);
    set_mode(4'h0, CS_STOP, 2'h1);
    cap_pin = 1'b1;
    idle(10);
    i_cpu.rd16(SEL_CAPT_LO, w16);
    check(w16, 16'h0200, "capt pin");
    i_cpu.rd8(SEL_FLAGS, b8);
    check(16'(b8 & 8'h20), 16'h0020, "capt flag");
    i_cpu.wr16(SEL_COUNT_LO, 16'h0300);
    set_mode(4'h0, CS_STOP, 2'h3);
    acomp_sel = 1'b1;
    idle(10);
    acomp = 1'b1;
    idle(12);
    i_cpu.rd16(SEL_CAPT_LO, w16);
    check(w16, 16'h0300, "capt acomp");
    // Prescaler pulses step the counter past compare A and wrap it at MAX
    i_cpu.wr16(SEL_CMPA_LO, 16'hFFFE);
    i_cpu.wr16(SEL_COUNT_LO, 16'hFFFD);
    i_cpu.wr8(SEL_FLAGS, 8'hFF);
    set_mode(4'h0, 3'h3, 2'h0);
    mark_a = n_a;
    mark_t = n_t;
    repeat (5) begin
      presc = 1'b1;
      idle(1);
      presc = 1'b0;
      idle(3);
    end
    i_cpu.rd16(SEL_COUNT_LO, w16);
    check(w16, 16'h0002, "presc count");
    check(16'(n_t - mark_t), 16'h0005, "tick pulses");
    check(16'(n_a - mark_a), 16'h0001, "match a");
    i_cpu.rd8(SEL_FLAGS, b8);
    check(16'(b8 & 8'h07), 16'h0003, "wrap and match flags");
    wrap_up();
  end
endmodule : tb_timer16_byte_access_core
